// >>> core/lpddr_decode_pkg.sv
package lpddr_decode_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;
  localparam int AP_BIT = 10;
  localparam int ROW_CTR_W = 13;
  localparam int CLK_PERIOD_NS = 25;
  localparam int PRECHARGE_PERIOD_NS = 30;
  localparam int ROW_ACTIVE_MIN_TIME_NS = 45;
  localparam int REFRESH_CYCLE_TIME_NS = 138;
  localparam int SELF_REFRESH_EXIT_DELAY_NS = 140;
  localparam int MODE_LOAD_DELAY_NS = 25;
  localparam int BURST_CYCLES = 2;
  localparam int PRECHARGE_PERIOD_CYC = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_ACTIVE_MIN_CYC = (ROW_ACTIVE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLE_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELF_REFRESH_EXIT_CYC = (SELF_REFRESH_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_LOAD_DELAY_CYC = (MODE_LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] MR_SEL_STD = 2'h0;
  localparam logic [1:0] MR_SEL_EXT = 2'h2;
  localparam logic [ADDR_W-1:0] MR_STD_RESET = 13'h0000;
  localparam logic [ADDR_W-1:0] MR_EXT_RESET = 13'h0000;
  localparam logic [2:0] ARRAY_REF_FULL = 3'h0;
  localparam logic [2:0] ARRAY_REF_HALF = 3'h1;
  localparam logic [2:0] ARRAY_REF_QUARTER = 3'h2;
  localparam int FIFO_DEPTH = 32;
  localparam int DATA_W = 32;
  localparam int MASK_W = 4;
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_BURST_STOP, CMD_DEEP_PD,
    CMD_PRECHARGE, CMD_AUTO_REFRESH, CMD_SELF_REFRESH, CMD_MODE_LOAD, CMD_ILLEGAL
  } cmd_type;
  typedef enum {BANK_IDLE, BANK_OPEN, BANK_PRECHARGING} bank_state_type;
  typedef enum {DEV_RUN, DEV_SELF_REFRESH, DEV_SR_EXIT, DEV_DEEP_PD} dev_state_type;
endpackage

// >>> core/lpddr_command_decoder.sv
// Overview of operation
// - mode load bank code picks standard/extended register
// - activate opens row until precharge to bank
// - read/write column a0-a9, a10 auto precharge
// - precharge a10 low one bank, high all
// - refresh with cke high auto, low self
// - refresh uses internal counter, ignores other pins
// - burst stop truncates latest read, row stays open; code cuts it only if that read had no auto precharge
// - shared code: cke high burst stop, low deep power-down
// - deselect and nop identical, operations continue
// - write byte stored only when mask low
// - precharged bank idle after precharge period
// - precharge to idle/precharging bank is nop
// - other-bank access allowed during auto precharge
// - auto precharge starts after burst and row_active_min_time
// - self refresh covers partial_array_refresh_setting portion
// - deep power down discards data, needs init
// - ras cas we levels decode to commands
`timescale 1ns/1ps
`default_nettype none

module lpddr_wr_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;
  assign in_ready_o = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem[rptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_r] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module lpddr_command_decoder
  import lpddr_decode_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CKE_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [lpddr_decode_pkg::BANK_W-1:0] BA_I,
  input wire logic [lpddr_decode_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic WDATA_VALID_I,
  output logic WDATA_READY_O,
  input wire logic [lpddr_decode_pkg::DATA_W-1:0] WDATA_I,
  input wire logic [lpddr_decode_pkg::MASK_W-1:0] WRITE_BYTE_MASK_I,
  input wire logic ARRAY_READY_I,
  output logic ARRAY_WR_O,
  output logic [lpddr_decode_pkg::DATA_W-1:0] ARRAY_WDATA_O,
  output logic [lpddr_decode_pkg::MASK_W-1:0] ARRAY_BYTE_EN_O,
  output logic [lpddr_decode_pkg::BANK_W-1:0] ARRAY_BANK_O,
  output logic [lpddr_decode_pkg::ADDR_W-1:0] ARRAY_ROW_O,
  output logic [lpddr_decode_pkg::COL_W-1:0] ARRAY_COL_O,
  output logic ARRAY_RD_O,
  output logic READ_STOP_O,
  output logic REFRESH_O,
  output logic [lpddr_decode_pkg::ROW_CTR_W-1:0] REFRESH_ROW_O,
  output logic [lpddr_decode_pkg::NUM_BANKS-1:0] REFRESH_BANKS_O,
  output logic [lpddr_decode_pkg::NUM_BANKS-1:0] BANK_OPEN_O,
  output logic [lpddr_decode_pkg::ADDR_W-1:0] MODE_STD_O,
  output logic [lpddr_decode_pkg::ADDR_W-1:0] MODE_EXT_O,
  output logic SELF_REFRESH_O,
  output logic DEEP_POWER_DOWN_O,
  output logic DATA_LOST_O
);
  import lpddr_decode_pkg::*;

  // pins come from the controller's clock: three-stage capture, act once stages 2 and 3 agree
  localparam int PIN_W = 5 + BANK_W + ADDR_W;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic [PIN_W-1:0] pin_s3_r;
  logic [PIN_W-1:0] pin_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1_r <= {1'b0, 4'hf, {(BANK_W+ADDR_W){1'b0}}};
      pin_s2_r <= {1'b0, 4'hf, {(BANK_W+ADDR_W){1'b0}}};
      pin_s3_r <= {1'b0, 4'hf, {(BANK_W+ADDR_W){1'b0}}};
      pin_r <= {1'b0, 4'hf, {(BANK_W+ADDR_W){1'b0}}};
    end else begin
      pin_s1_r <= {CKE_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, BA_I, ADDR_I};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) begin
        pin_r <= pin_s3_r;
      end
    end
  end
  logic [PIN_W-1:0] pin_prev_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pin_prev_r <= {1'b0, 4'hf, {(BANK_W+ADDR_W){1'b0}}};
    end else begin
      pin_prev_r <= pin_r;
    end
  end
  // one command per settled change of the pin word
  logic new_cmd;
  assign new_cmd = (pin_r != pin_prev_r);

  logic cke;
  logic [3:0] ctl;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  assign cke = pin_r[PIN_W-1];
  assign ctl = pin_r[PIN_W-2 -: 4];
  assign ba = pin_r[BANK_W+ADDR_W-1 -: BANK_W];
  assign addr = pin_r[ADDR_W-1:0];

  cmd_type cmd;
  always_comb begin
    cmd = CMD_NOP;
    if (!ctl[3] && new_cmd) begin
      case (ctl[2:0])
        3'h7: cmd = CMD_NOP;
        3'h3: cmd = CMD_ACTIVE;
        3'h5: cmd = CMD_READ;
        3'h4: cmd = CMD_WRITE;
        3'h6: cmd = cke ? CMD_BURST_STOP : CMD_DEEP_PD;
        3'h2: cmd = CMD_PRECHARGE;
        3'h1: cmd = cke ? CMD_AUTO_REFRESH : CMD_SELF_REFRESH;
        3'h0: cmd = CMD_MODE_LOAD;
        default: cmd = CMD_ILLEGAL;
      endcase
    end
  end

  dev_state_type dev_r;
  logic [7:0] busy_r;
  logic run;
  assign run = (dev_r == DEV_RUN) && (busy_r == '0);

  // banks, generated per bank
  bank_state_type bank_r [NUM_BANKS];
  logic [ADDR_W-1:0] row_r [NUM_BANKS];
  logic [7:0] tmr_r [NUM_BANKS];
  logic [7:0] ras_r [NUM_BANKS];
  logic [NUM_BANKS-1:0] ap_r;
  logic all_idle;
  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (bank_r[i] != BANK_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic hit;
    logic pre_hit;
    assign hit = run && (ba == BANK_W'(b));
    assign pre_hit = run && (cmd == CMD_PRECHARGE) && (addr[AP_BIT] || ba == BANK_W'(b));
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
        bank_r[b] <= BANK_IDLE;
        row_r[b] <= '0;
        tmr_r[b] <= '0;
        ras_r[b] <= '0;
        ap_r[b] <= 1'b0;
      end else begin
        if (ras_r[b] != '0) begin
          ras_r[b] <= ras_r[b] - 8'h01;
        end
        case (bank_r[b])
          BANK_IDLE: begin
            if (hit && cmd == CMD_ACTIVE) begin
              bank_r[b] <= BANK_OPEN;
              row_r[b] <= addr;
              ras_r[b] <= 8'(ROW_ACTIVE_MIN_CYC);
            end
          end
          BANK_OPEN: begin
            if (ap_r[b]) begin
              // auto precharge waits out the burst and row_active_min_time
              if (tmr_r[b] != '0) begin
                tmr_r[b] <= tmr_r[b] - 8'h01;
              end else if (ras_r[b] == '0) begin
                bank_r[b] <= BANK_PRECHARGING;
                tmr_r[b] <= 8'(PRECHARGE_PERIOD_CYC);
                ap_r[b] <= 1'b0;
              end
            end else if (pre_hit) begin
              bank_r[b] <= BANK_PRECHARGING;
              tmr_r[b] <= 8'(PRECHARGE_PERIOD_CYC);
            end else if (hit && (cmd == CMD_READ || cmd == CMD_WRITE) && addr[AP_BIT]) begin
              ap_r[b] <= 1'b1;
              tmr_r[b] <= 8'(BURST_CYCLES);
            end
          end
          BANK_PRECHARGING: begin
            if (tmr_r[b] != '0) begin
              tmr_r[b] <= tmr_r[b] - 8'h01;
            end else begin
              bank_r[b] <= BANK_IDLE;
            end
          end
          default: bank_r[b] <= BANK_IDLE;
        endcase
      end
    end
  end

  // device-wide mode: refresh, self refresh, deep power down, mode loads
  logic [ROW_CTR_W-1:0] ref_row_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      dev_r <= DEV_RUN;
      busy_r <= '0;
    end else begin
      case (dev_r)
        DEV_RUN: begin
          if (busy_r != '0) begin
            busy_r <= busy_r - 8'h01;
          end else if (cmd == CMD_AUTO_REFRESH) begin
            busy_r <= 8'(REFRESH_CYCLE_CYC);
          end else if (cmd == CMD_MODE_LOAD) begin
            busy_r <= 8'(MODE_LOAD_DELAY_CYC);
          end else if (cmd == CMD_SELF_REFRESH) begin
            dev_r <= DEV_SELF_REFRESH;
          end else if (cmd == CMD_DEEP_PD) begin
            dev_r <= DEV_DEEP_PD;
          end
        end
        DEV_SELF_REFRESH: begin
          if (cke) begin
            dev_r <= DEV_SR_EXIT;
            busy_r <= 8'(SELF_REFRESH_EXIT_CYC);
          end
        end
        DEV_SR_EXIT: begin
          if (busy_r != '0) begin
            busy_r <= busy_r - 8'h01;
          end else begin
            dev_r <= DEV_RUN;
          end
        end
        DEV_DEEP_PD: begin
          if (cke) begin
            dev_r <= DEV_RUN;
          end
        end
        default: dev_r <= DEV_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      MODE_STD_O <= MR_STD_RESET;
      MODE_EXT_O <= MR_EXT_RESET;
    end else if (run && cmd == CMD_MODE_LOAD && all_idle) begin
      if (ba == MR_SEL_STD) begin
        MODE_STD_O <= addr;
      end else if (ba == MR_SEL_EXT) begin
        MODE_EXT_O <= addr;
      end
    end
  end

  // refresh pulses: internal row counter, address pins unused
  logic [NUM_BANKS-1:0] part_banks;
  always_comb begin
    case (MODE_EXT_O[2:0])
      ARRAY_REF_HALF: part_banks = 4'h3;
      ARRAY_REF_QUARTER: part_banks = 4'h1;
      default: part_banks = 4'hf;
    endcase
  end
  logic [7:0] sr_tick_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      REFRESH_O <= 1'b0;
      REFRESH_ROW_O <= '0;
      REFRESH_BANKS_O <= '0;
      ref_row_r <= '0;
      sr_tick_r <= '0;
    end else begin
      REFRESH_O <= 1'b0;
      sr_tick_r <= (dev_r == DEV_SELF_REFRESH) ? sr_tick_r + 8'h01 : '0;
      if (run && cmd == CMD_AUTO_REFRESH) begin
        REFRESH_O <= 1'b1;
        REFRESH_ROW_O <= ref_row_r;
        REFRESH_BANKS_O <= 4'hf;
        ref_row_r <= ref_row_r + 1'b1;
      end else if (dev_r == DEV_SELF_REFRESH && sr_tick_r == 8'hff) begin
        REFRESH_O <= 1'b1;
        REFRESH_ROW_O <= ref_row_r;
        REFRESH_BANKS_O <= part_banks;
        ref_row_r <= ref_row_r + 1'b1;
      end
    end
  end

  // column commands and burst stop
  logic [NUM_BANKS-1:0] open_vec;
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      open_vec[i] = (bank_r[i] == BANK_OPEN);
    end
  end
  logic [BANK_W-1:0] last_rd_bank_r;
  logic last_rd_ap_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ARRAY_RD_O <= 1'b0;
      READ_STOP_O <= 1'b0;
      ARRAY_BANK_O <= '0;
      ARRAY_ROW_O <= '0;
      ARRAY_COL_O <= '0;
      last_rd_bank_r <= '0;
      last_rd_ap_r <= 1'b1;
    end else begin
      ARRAY_RD_O <= 1'b0;
      READ_STOP_O <= 1'b0;
      if (run && open_vec[ba] && !ap_r[ba] && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
        ARRAY_BANK_O <= ba;
        ARRAY_ROW_O <= row_r[ba];
        ARRAY_COL_O <= addr[COL_W-1:0];
        if (cmd == CMD_READ) begin
          ARRAY_RD_O <= 1'b1;
          last_rd_bank_r <= ba;
          last_rd_ap_r <= addr[AP_BIT];
        end
      end
      // only a read without auto precharge is cut; its row is left open
      if (run && cmd == CMD_BURST_STOP && !last_rd_ap_r) begin
        READ_STOP_O <= 1'b1;
        ARRAY_BANK_O <= last_rd_bank_r;
      end
    end
  end

  // write data path through the fifo; mask high keeps the byte
  logic fifo_valid;
  logic fifo_ready;
  logic [DATA_W+MASK_W-1:0] fifo_data;
  lpddr_wr_fifo #(
    .WIDTH(DATA_W + MASK_W),
    .DEPTH(FIFO_WORDS)
  ) i_lpddr_wr_fifo (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    // only words taken by the registered handshake enter, else space_r drifts from the buffer
    .in_valid_i(WDATA_VALID_I && WDATA_READY_O),
    .in_ready_o(),
    .in_data_i({WRITE_BYTE_MASK_I, WDATA_I}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_data)
  );
  // registered copy of fifo space for the ready output
  logic [5:0] space_r;
  assign fifo_ready = ARRAY_READY_I && !ARRAY_WR_O && (dev_r == DEV_RUN);
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ARRAY_WR_O <= 1'b0;
      ARRAY_WDATA_O <= '0;
      ARRAY_BYTE_EN_O <= '0;
      WDATA_READY_O <= 1'b0;
      space_r <= 6'(FIFO_WORDS);
    end else begin
      ARRAY_WR_O <= 1'b0;
      space_r <= space_r - 6'(WDATA_VALID_I && WDATA_READY_O) + 6'(fifo_valid && fifo_ready);
      // deasserts one word early so the registered ready never overfills
      WDATA_READY_O <= (space_r > 6'h01);
      if (fifo_valid && fifo_ready) begin
        ARRAY_WR_O <= 1'b1;
        ARRAY_WDATA_O <= fifo_data[DATA_W-1:0];
        ARRAY_BYTE_EN_O <= ~fifo_data[DATA_W+MASK_W-1:DATA_W];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      BANK_OPEN_O <= '0;
      SELF_REFRESH_O <= 1'b0;
      DEEP_POWER_DOWN_O <= 1'b0;
      DATA_LOST_O <= 1'b0;
    end else begin
      BANK_OPEN_O <= open_vec;
      SELF_REFRESH_O <= (dev_r == DEV_SELF_REFRESH);
      DEEP_POWER_DOWN_O <= (dev_r == DEV_DEEP_PD);
      if (dev_r == DEV_DEEP_PD) begin
        DATA_LOST_O <= 1'b1;
      end else if (run && cmd == CMD_MODE_LOAD) begin
        DATA_LOST_O <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// >>> test/lpddr_command_decoder_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lpddr_command_decoder_sva
  import lpddr_decode_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic ARRAY_RD_O,
  input wire logic [lpddr_decode_pkg::BANK_W-1:0] ARRAY_BANK_O,
  input wire logic READ_STOP_O,
  input wire logic REFRESH_O,
  input wire logic [lpddr_decode_pkg::NUM_BANKS-1:0] REFRESH_BANKS_O,
  input wire logic [lpddr_decode_pkg::NUM_BANKS-1:0] BANK_OPEN_O,
  input wire logic [lpddr_decode_pkg::ADDR_W-1:0] MODE_STD_O,
  input wire logic [lpddr_decode_pkg::ADDR_W-1:0] MODE_EXT_O,
  input wire logic SELF_REFRESH_O,
  input wire logic DEEP_POWER_DOWN_O,
  input wire logic DATA_LOST_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  logic [3:0] act_cnt_r;
  // pin word takes several edges to settle, so remember a recent activate
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) act_cnt_r <= 4'h0;
    else if (!CS_N_I && !RAS_N_I && CAS_N_I && WE_N_I) act_cnt_r <= 4'h8;
    else if (act_cnt_r != 4'h0) act_cnt_r <= act_cnt_r - 4'h1;
  end
  property p_rd_open;
    ARRAY_RD_O |-> BANK_OPEN_O[ARRAY_BANK_O];
  endproperty
  a_rd_open: assert property (p_rd_open) else $error("read on closed bank");
  property p_open_cause;
    (BANK_OPEN_O & ~$past(BANK_OPEN_O)) != 4'h0 |-> act_cnt_r != 4'h0;
  endproperty
  a_open_cause: assert property (p_open_cause) else $error("bank opened without activate");
  property p_stop_open;
    READ_STOP_O |-> BANK_OPEN_O[ARRAY_BANK_O] && !ARRAY_RD_O;
  endproperty
  a_stop_open: assert property (p_stop_open) else $error("burst stop closed row");
  property p_ref_gap;
    REFRESH_O |=> !REFRESH_O [*5];
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("refresh inside refresh cycle");
  property p_sr_quiet;
    SELF_REFRESH_O |-> !ARRAY_RD_O && !READ_STOP_O;
  endproperty
  a_sr_quiet: assert property (p_sr_quiet) else $error("access during self refresh");
  property p_full_banks;
    REFRESH_O && SELF_REFRESH_O && MODE_EXT_O[2:0] == ARRAY_REF_FULL |-> REFRESH_BANKS_O == 4'hf;
  endproperty
  a_full_banks: assert property (p_full_banks) else $error("full self refresh missed banks");
  property p_deep_pd_lost;
    $rose(DEEP_POWER_DOWN_O) |-> ##[0:2] DATA_LOST_O;
  endproperty
  a_deep_pd_lost: assert property (p_deep_pd_lost) else $error("deep power down kept data");
  property p_mode_idle;
    !$stable(MODE_STD_O) || !$stable(MODE_EXT_O) |-> $past(BANK_OPEN_O) == 4'h0;
  endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("mode load with open bank");
  property p_nop_quiet;
    CS_N_I [*5] |-> !ARRAY_RD_O && !READ_STOP_O;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("command while deselected");
  c_read: cover property (ARRAY_RD_O);
  c_sr: cover property (SELF_REFRESH_O && REFRESH_O);
  c_deep_pd: cover property ($rose(DEEP_POWER_DOWN_O));
  c_sr_part: cover property (REFRESH_O && SELF_REFRESH_O && REFRESH_BANKS_O != 4'hf);
endmodule
bind lpddr_command_decoder lpddr_command_decoder_sva i_lpddr_command_decoder_sva (.CLK_SYS_I, .RST_I, .CS_N_I,
  .RAS_N_I, .CAS_N_I, .WE_N_I, .ARRAY_RD_O, .ARRAY_BANK_O, .READ_STOP_O, .REFRESH_O, .REFRESH_BANKS_O, .BANK_OPEN_O,
  .MODE_STD_O, .MODE_EXT_O, .SELF_REFRESH_O, .DEEP_POWER_DOWN_O, .DATA_LOST_O);
`default_nettype wire

// >>> test/lpddr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpddr_ctrl_model (
  input wire logic clk_i,
  output logic [4:0] pins_o,
  output logic [1:0] ba_o,
  output logic [12:0] addr_o
);
  // pins_o is {cke, cs_n, ras_n, cas_n, we_n}
  initial begin
    pins_o = 5'h17;
    ba_o = 2'h0;
    addr_o = 13'h0000;
  end
  task automatic issue(input logic [4:0] pins, input logic [1:0] ba, input logic [12:0] addr);
    @(posedge clk_i);
    #1;
    pins_o = pins;
    ba_o = ba;
    addr_o = addr;
    repeat (6) @(posedge clk_i);
    #1;
    // nop keeps cke so a power mode stays entered; address no longer valid
    pins_o = {pins[4], 4'h7};
    ba_o = ~ba;
    addr_o = ~addr;
    // long gap outlasts every busy period of the device
    repeat (12) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> test/lpddr_command_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lpddr_command_decoder_tb;
  import lpddr_decode_pkg::*;
  // pins {cke, cs_n, ras_n, cas_n, we_n}; pulses {read, stop, refresh}
  typedef struct packed {logic [4:0] pins; logic [1:0] ba; logic [12:0] addr; logic [2:0] pulses; logic [3:0] open;} row_type;
  row_type rows [14] = '{
    '{5'h13, 2'h1, 13'h1abc, 3'h0, 4'h2}, '{5'h15, 2'h1, 13'h0155, 3'h4, 4'h2},
    '{5'h16, 2'h0, 13'h0000, 3'h2, 4'h2}, '{5'h15, 2'h2, 13'h0011, 3'h0, 4'h2},
    '{5'h1b, 2'h0, 13'h0000, 3'h0, 4'h2}, '{5'h12, 2'h1, 13'h0000, 3'h0, 4'h0},
    '{5'h12, 2'h1, 13'h0000, 3'h0, 4'h0}, '{5'h13, 2'h0, 13'h0002, 3'h0, 4'h1},
    '{5'h13, 2'h3, 13'h0003, 3'h0, 4'h9}, '{5'h12, 2'h2, 13'h0400, 3'h0, 4'h0},
    '{5'h11, 2'h3, 13'h1fff, 3'h1, 4'h0}, '{5'h10, 2'h0, 13'h0123, 3'h0, 4'h0},
    '{5'h10, 2'h2, 13'h0100, 3'h0, 4'h0}, '{5'h10, 2'h1, 13'h1555, 3'h0, 4'h0}
  };
  logic clk, rst, wvalid, aready, wready, awr, ard, rstop, rfr, sr, deep_pd, lost;
  logic [4:0] pins;
  logic [1:0] ba, abank, l_bank;
  logic [12:0] addr, arow, rrow, mstd, mext, l_row;
  logic [31:0] wdata, adata;
  logic [3:0] wmask, ben, rbanks, bopen;
  logic [9:0] acol, l_col;
  logic [35:0] exp_q [$];
  int error_cnt = 0, num_checks = 0, n_rd = 0, n_stop = 0, n_rf = 0, s_rd, s_stop, s_rf, i, k;
  lpddr_ctrl_model i_lpddr_ctrl_model (.clk_i(clk), .pins_o(pins), .ba_o(ba), .addr_o(addr));
  lpddr_command_decoder i_lpddr_command_decoder (
    .CLK_SYS_I(clk), .RST_I(rst), .CKE_I(pins[4]), .CS_N_I(pins[3]), .RAS_N_I(pins[2]), .CAS_N_I(pins[1]),
    .WE_N_I(pins[0]), .BA_I(ba), .ADDR_I(addr), .WDATA_VALID_I(wvalid), .WDATA_READY_O(wready), .WDATA_I(wdata),
    .WRITE_BYTE_MASK_I(wmask), .ARRAY_READY_I(aready), .ARRAY_WR_O(awr), .ARRAY_WDATA_O(adata),
    .ARRAY_BYTE_EN_O(ben), .ARRAY_BANK_O(abank), .ARRAY_ROW_O(arow), .ARRAY_COL_O(acol), .ARRAY_RD_O(ard),
    .READ_STOP_O(rstop), .REFRESH_O(rfr), .REFRESH_ROW_O(rrow), .REFRESH_BANKS_O(rbanks), .BANK_OPEN_O(bopen),
    .MODE_STD_O(mstd), .MODE_EXT_O(mext), .SELF_REFRESH_O(sr), .DEEP_POWER_DOWN_O(deep_pd), .DATA_LOST_O(lost)
  );
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmd(input logic [4:0] p, input logic [1:0] b, input logic [12:0] a);
    i_lpddr_ctrl_model.issue(p, b, a);
  endtask
  always @(posedge clk) begin
    n_rd <= n_rd + int'(ard);
    n_stop <= n_stop + int'(rstop);
    n_rf <= n_rf + int'(rfr);
    if (ard) {l_bank, l_row, l_col} <= {abank, arow, acol};
    if (awr) begin
      chk("wdata", exp_q[0][31:0], adata);
      chk("byte_en", {28'h0, ~exp_q[0][35:32]}, {28'h0, ben});
      void'(exp_q.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    wvalid = 1'b0;
    aready = 1'b0;
    wdata = 32'h0;
    wmask = 4'h0;
    repeat (4) @(posedge clk);
    chk("open_rst", 32'h0, 32'(bopen));
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    chk("ready_rst", 32'h1, 32'(wready));
    for (i = 0; i < 14; i++) begin
      s_rd = n_rd;
      s_stop = n_stop;
      s_rf = n_rf;
      cmd(rows[i].pins, rows[i].ba, rows[i].addr);
      chk("pulses", 32'(rows[i].pulses), 32'(4 * (n_rd - s_rd) + 2 * (n_stop - s_stop) + n_rf - s_rf));
      chk("open", 32'(rows[i].open), 32'(bopen));
      if (rows[i].pulses[2]) chk("rd_col", {20'h0, rows[i].ba, rows[i].addr[9:0]}, {20'h0, l_bank, l_col});
    end
    chk("rd_row", 32'h1abc, 32'(l_row));
    chk("mode_std", 32'h123, 32'(mstd));
    chk("mode_ext", 32'h100, 32'(mext));
    cmd(5'h13, 2'h2, 13'h0777);
    s_rd = n_rd;
    cmd(5'h15, 2'h2, 13'h07ff);
    chk("ap_rd", 32'h1, 32'(n_rd - s_rd));
    chk("ap_addr", {7'h0, 2'h2, 13'h0777, 10'h3ff}, {7'h0, l_bank, l_row, l_col});
    chk("ap_open", 32'h0, 32'(bopen));
    cmd(5'h13, 2'h0, 13'h0010);
    cmd(5'h14, 2'h0, 13'h0020);
    #1;
    wvalid = 1'b1;
    // far side stalls, so the buffer must refuse before the loop ends
    for (k = 0; k < 40; k++) begin
      wdata = {4{8'(k)}};
      wmask = 4'(k);
      @(posedge clk);
      if (wready !== 1'b1) break;
      exp_q.push_back({wmask, wdata});
      #1;
    end
    chk("fill_refused", 32'(FIFO_DEPTH), 32'(k));
    #1 aready = 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (wready === 1'b1) break;
    end
    chk("ready_wait", 32'h1, 32'(i < 8));
    exp_q.push_back({wmask, wdata});
    #1 wvalid = 1'b0;
    for (i = 0; i < 300 && exp_q.size() > 0; i++) begin
      @(posedge clk);
      #1 aready = i[1];
    end
    chk("drained", 32'h0, 32'(exp_q.size()));
    cmd(5'h12, 2'h0, 13'h0400);
    cmd(5'h01, 2'h0, 13'h0000);
    chk("sr_on", 32'h1, 32'(sr));
    for (i = 0; i < 600 && rfr !== 1'b1; i++) @(posedge clk);
    chk("sr_banks", 32'h1f, {27'h0, rfr, rbanks});
    chk("sr_row", 32'h1, 32'(rrow));
    cmd(5'h17, 2'h0, 13'h0000);
    chk("sr_off", 32'h0, 32'(sr));
    cmd(5'h06, 2'h0, 13'h0000);
    chk("deep_pd", 32'h3, 32'({deep_pd, lost}));
    cmd(5'h17, 2'h0, 13'h0000);
    cmd(5'h10, 2'h0, 13'h0031);
    chk("deep_pd_init", 32'h31, {17'h0, deep_pd, lost, mstd});
    cmd(5'h10, 2'h2, 13'h0001);
    cmd(5'h01, 2'h0, 13'h0000);
    for (i = 0; i < 600 && rfr !== 1'b1; i++) @(posedge clk);
    chk("sr_half", 32'h13, {27'h0, rfr, rbanks});
    chk("sr_row2", 32'h2, 32'(rrow));
    cmd(5'h17, 2'h0, 13'h0000);
    cmd(5'h13, 2'h3, 13'h0005);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    chk("mid_rst", 32'h0, {15'h0, bopen, mstd});
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    chk("ready_rst2", 32'h1, 32'(wready));
    cmd(5'h13, 2'h1, 13'h0044);
    chk("open_rst2", 32'h2, 32'(bopen));
    summarize();
  end
endmodule
`default_nettype wire
